// File: gsp_master.sv
/*
 * Behavioural SPI master facing the gyro serial register port.
 * Assumes mode 3 framing, a 64 ns serial clock, and a caller that runs one frame at a time.
 */
`default_nettype none
module gsp_master (
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_din,
    input wire logic spi_dout,
    input wire logic spi_dout_oe,
    output logic [15:0] rx_word,
    output logic rx_tgl
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Line state
    // ****************************************
    // A released output line shows the inverse of spi_dout, never the driven value
    wire miso = spi_dout_oe ? spi_dout : ~spi_dout;
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b1;
        spi_din = 1'b0;
        rx_word = 16'h0000;
        rx_tgl = 1'b0;
    end
    // ****************************************
    // One frame
    // ****************************************
    // Odd offset keeps serial edges away from core clock edges
    task automatic xfer(input logic [15:0] w);
        logic [15:0] rx;
        rx = 16'h0000;
        #1.3;
        spi_cs_n <= 1'b0;
        #64;
        for (int i = 15; i >= 0; i--) begin
            spi_sclk <= 1'b0;
            spi_din <= w[i];
            #32;
            spi_sclk <= 1'b1;
            rx = {rx[14:0], miso};
            #32;
        end
        spi_cs_n <= 1'b1;
        spi_din <= ~w[0];
        rx_word <= rx;
        rx_tgl <= ~rx_tgl;
        #64;
    endtask : xfer
    // Clock and data wiggled with select high; the port must ignore them
    task automatic stray(input logic [15:0] pat);
        for (int i = 15; i >= 0; i--) begin
            spi_sclk <= i[0];
            spi_din <= pat[i];
            #32;
        end
        spi_sclk <= 1'b1;
        #64;
    endtask : stray
endmodule : gsp_master
`default_nettype wire

// File: gsp_pkg.sv
/*
 * Shared constants of the gyro serial register port: frame layout,
 * byte addresses of the output registers, field positions, reset values.
 * Assumes a single 200 MHz core clock and an external SPI master.
 */
`default_nettype none
package gsp_pkg;
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned CNT_W = 5;
    localparam logic [4:0] CNT_LAST = 5'h10;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned WR_BIT = 15;
    localparam int unsigned ZERO_BIT = 14;
    localparam int unsigned ADDR_HI = 13;
    localparam int unsigned ADDR_LO = 8;
    localparam int unsigned FLAG_BIT = 15;
    localparam int unsigned ALARM_BIT = 14;
    // Byte addresses of the output registers (lower byte address even)
    localparam logic [5:0] A_ENDUR = 6'h00;
    localparam logic [5:0] A_SUPPLY = 6'h02;
    localparam logic [5:0] A_RATE = 6'h04;
    localparam logic [5:0] A_AUX = 6'h0a;
    localparam logic [5:0] A_TEMP = 6'h0c;
    localparam logic [5:0] A_ANGLE = 6'h0e;
    localparam logic [5:0] A_CMD = 6'h3e;
    // Command byte bits
    localparam int unsigned CMD_NULL_BIT = 0;
    localparam int unsigned CMD_SWRST_BIT = 7;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [13:0] ANGLE_RST = 14'h0000;
    // Start-up hold after a pin reset, in microseconds
    localparam int unsigned START_US = 1;
    localparam int unsigned CLK_MHZ = 200;
    localparam logic [7:0] START_CYC = 8'(START_US * CLK_MHZ);
endpackage : gsp_pkg
`default_nettype wire

// File: gsp_port.sv
/*
 * Serial register port of a rate-gyro sensor: SPI mode 3 slave, 16-bit
 * full-duplex frames, byte-addressed writes, whole-register reads,
 * relative-angle accumulator, new-data flags and start-up sequencing.
 * Assumes the SPI pins are asynchronous to clk and that the sample path
 * delivers one-cycle strobes with raw data from the core clock.
 */
`default_nettype none
module gsp_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic rst_pin_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_din,
    output logic spi_dout,
    output logic spi_dout_oe,
    input wire logic sample_stb,
    input wire logic [13:0] raw_rate,
    input wire logic [13:0] rate_bias,
    input wire logic [13:0] user_offset,
    input wire logic [11:0] supply_raw,
    input wire logic [11:0] aux_raw,
    input wire logic [11:0] temp_raw,
    input wire logic alarm,
    output logic startup_busy,
    output logic [7:0] wr_addr_data,
    output logic [5:0] wr_addr,
    output logic wr_stb
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [2:0] cs_s_q, cs_s_d, ck_s_q, ck_s_d, di_s_q, di_s_d, rp_s_q, rp_s_d;
    logic ck_prev_q, ck_prev_d;
    logic cs_n, ck, di, ck_rise, ck_fall, cs_fall;

    // Three stages per pin; stage 1 feeds only stage 2
    always_comb begin
        cs_s_d = {cs_s_q[1:0], spi_cs_n};
        ck_s_d = {ck_s_q[1:0], spi_sclk};
        di_s_d = {di_s_q[1:0], spi_din};
        rp_s_d = {rp_s_q[1:0], rst_pin_n};
        ck_prev_d = ck_s_q[1];
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_s_q <= 3'h7;
            ck_s_q <= 3'h7;
            di_s_q <= 3'h0;
            rp_s_q <= 3'h7;
            ck_prev_q <= 1'b1;
        end else begin
            cs_s_q <= cs_s_d;
            ck_s_q <= ck_s_d;
            di_s_q <= di_s_d;
            rp_s_q <= rp_s_d;
            ck_prev_q <= ck_prev_d;
        end
    end
    assign cs_n = cs_s_q[1];
    assign ck = cs_s_q[1] ? 1'b1 : ck_s_q[1];
    assign di = di_s_q[1];
    // Edges counted only inside a frame
    assign ck_rise = ~cs_n & ck & ~ck_prev_q;
    assign ck_fall = ~cs_n & ~ck & ck_prev_q;
    assign cs_fall = ~cs_n & cs_s_q[2];

    // ****************************************
    // Reset pin and start-up sequence
    // ****************************************
    logic [7:0] start_q, start_d;
    logic pin_rst;
    assign pin_rst = ~rp_s_q[1];

    // Hold busy while the pin is low and for a short settle after release
    always_comb begin
        start_d = start_q;
        if (pin_rst) begin
            start_d = gsp_pkg::START_CYC;
        end else if (start_q != 8'h00) begin
            start_d = start_q - 8'h01;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_q <= gsp_pkg::START_CYC;
        end else begin
            start_q <= start_d;
        end
    end

    // ****************************************
    // Output data registers
    // ****************************************
    logic [13:0] rate_q, rate_d, angle_q, angle_d;
    logic [11:0] sup_q, sup_d, aux_q, aux_d, temp_q, temp_d;
    logic nd_q, nd_d;
    logic clr_angle, read_done, take;
    logic [13:0] cal;

    // Calibrated rate: raw minus factory bias plus user offset
    assign cal = raw_rate - rate_bias + user_offset;
    assign take = sample_stb & ~startup_busy;

    always_comb begin
        rate_d = rate_q;
        sup_d = sup_q;
        aux_d = aux_q;
        temp_d = temp_q;
        angle_d = angle_q;
        nd_d = nd_q;
        if (read_done) begin
            nd_d = 1'b0;
        end
        if (take) begin
            rate_d = cal;
            sup_d = supply_raw;
            aux_d = aux_raw;
            temp_d = temp_raw;
            angle_d = angle_q + cal;
            nd_d = 1'b1;
        end
        if (clr_angle | pin_rst) begin
            angle_d = gsp_pkg::ANGLE_RST;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_q <= 14'h0000;
            sup_q <= 12'h000;
            aux_q <= 12'h000;
            temp_q <= 12'h000;
            angle_q <= gsp_pkg::ANGLE_RST;
            nd_q <= 1'b0;
        end else begin
            rate_q <= rate_d;
            sup_q <= sup_d;
            aux_q <= aux_d;
            temp_q <= temp_d;
            angle_q <= angle_d;
            nd_q <= nd_d;
        end
    end

    // Either byte address selects the whole register
    function automatic logic [15:0] reg_word(input logic [5:0] a, input logic nd,
                                             input logic al);
        logic [13:0] body;
        body = 14'h0000;
        unique case ({a[5:1], 1'b0})
            gsp_pkg::A_SUPPLY: body = {2'b00, sup_q};
            gsp_pkg::A_RATE: body = rate_q;
            gsp_pkg::A_AUX: body = {2'b00, aux_q};
            gsp_pkg::A_TEMP: body = {2'b00, temp_q};
            gsp_pkg::A_ANGLE: body = angle_q;
            default: body = 14'h0000;
        endcase
        reg_word = {nd, al, body};
    endfunction : reg_word

    // ****************************************
    // Serial frame engine
    // ****************************************
    logic [15:0] sh_in_q, sh_in_d, sh_out_q, sh_out_d, next_q, next_d;
    logic [4:0] cnt_q, cnt_d;
    logic dout_q, dout_d, oe_q, oe_d, wr_q, wr_d, busy_q;
    logic [5:0] wa_q, wa_d;
    logic [7:0] wd_q, wd_d;
    logic frame_end, pend_q, pend_d;
    logic [15:0] word;

    assign word = {sh_in_q[14:0], di};
    assign frame_end = ck_rise & (cnt_q == gsp_pkg::CNT_LAST - 5'h01);
    assign clr_angle = wr_q & (wa_q == gsp_pkg::A_CMD)
                       & (wd_q[gsp_pkg::CMD_NULL_BIT] | wd_q[gsp_pkg::CMD_SWRST_BIT]);
    assign read_done = cs_fall & pend_q;

    always_comb begin
        sh_in_d = sh_in_q;
        sh_out_d = sh_out_q;
        next_d = next_q;
        cnt_d = cnt_q;
        dout_d = dout_q;
        oe_d = ~cs_n;
        wr_d = 1'b0;
        wa_d = wa_q;
        wd_d = wd_q;
        pend_d = pend_q;
        if (cs_n) begin
            cnt_d = 5'h00;
        end else if (cs_fall) begin
            sh_out_d = next_q;
            dout_d = next_q[15];
        end
        if (ck_fall && cnt_q != 5'h00) begin
            sh_out_d = {sh_out_q[14:0], 1'b0};
            dout_d = sh_out_q[14];
        end
        if (read_done) begin
            pend_d = 1'b0;
        end
        if (ck_rise && cnt_q < gsp_pkg::CNT_LAST) begin
            sh_in_d = word;
            cnt_d = cnt_q + 5'h01;
        end
        if (frame_end && !startup_busy) begin
            if (word[gsp_pkg::WR_BIT] && !word[gsp_pkg::ZERO_BIT]) begin
                wr_d = 1'b1;
                wa_d = word[gsp_pkg::ADDR_HI:gsp_pkg::ADDR_LO];
                wd_d = word[7:0];
            end else if (!word[gsp_pkg::WR_BIT] && !word[gsp_pkg::ZERO_BIT]) begin
                next_d = reg_word(word[gsp_pkg::ADDR_HI:gsp_pkg::ADDR_LO], nd_q,
                                  alarm);
                pend_d = 1'b1;
            end
        end
        // A sample after the read capture is still unread: keep its flag up
        if (take) begin
            pend_d = 1'b0;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_in_q <= gsp_pkg::REG_RST;
            sh_out_q <= gsp_pkg::REG_RST;
            next_q <= gsp_pkg::REG_RST;
            cnt_q <= 5'h00;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
            wr_q <= 1'b0;
            wa_q <= 6'h00;
            wd_q <= 8'h00;
            pend_q <= 1'b0;
            busy_q <= 1'b1;
        end else begin
            sh_in_q <= sh_in_d;
            sh_out_q <= sh_out_d;
            next_q <= next_d;
            cnt_q <= cnt_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            wr_q <= wr_d;
            wa_q <= wa_d;
            wd_q <= wd_d;
            pend_q <= pend_d;
            busy_q <= pin_rst | (start_q != 8'h00);
        end
    end
    assign spi_dout = dout_q;
    assign spi_dout_oe = oe_q;
    assign startup_busy = busy_q;
    assign wr_stb = wr_q;
    assign wr_addr = wa_q;
    assign wr_addr_data = wd_q;

    // ****************************************
    // Checks
    // ****************************************
    chk_oe_off_idle: assert property (@(posedge clk) disable iff (rst)
        cs_n |=> !spi_dout_oe) else $error("dout driven while deselected");
    chk_no_count_idle: assert property (@(posedge clk) disable iff (rst)
        cs_n |=> cnt_q == 5'h00) else $error("count moved while deselected");
    chk_cnt_bound: assert property (@(posedge clk) disable iff (rst)
        cnt_q <= gsp_pkg::CNT_LAST) else $error("frame count overran");
    chk_write_pulse: assert property (@(posedge clk) disable iff (rst)
        wr_stb |=> !wr_stb) else $error("write strobe longer than one cycle");
    chk_angle_null: assert property (@(posedge clk) disable iff (rst)
        clr_angle |=> angle_q == 14'h0000) else $error("angle not cleared");
    chk_angle_sum: assert property (@(posedge clk) disable iff (rst)
        take && !clr_angle && !pin_rst |=> angle_q == $past(angle_q) + $past(cal))
        else $error("angle did not integrate");
    chk_nd_set: assert property (@(posedge clk) disable iff (rst)
        take |=> nd_q) else $error("new data flag not set");
    chk_nd_clear: assert property (@(posedge clk) disable iff (rst)
        read_done && !take |=> !nd_q) else $error("new data flag not cleared");
    chk_first_bit: assert property (@(posedge clk) disable iff (rst)
        cs_fall |=> spi_dout == $past(next_q[15])) else $error("first bit not msb");
    chk_busy_no_write: assert property (@(posedge clk) disable iff (rst)
        startup_busy |=> !wr_stb) else $error("write taken during start-up");
    chk_startup_hold: assert property (@(posedge clk) disable iff (rst)
        pin_rst |=> startup_busy [*2]) else $error("start-up not held");
endmodule : gsp_port
`default_nettype wire

// File: tb_gsp_port.sv
/*
 * Self-checking bench of the gyro serial register port.
 * Assumes the SPI master model and the design package are compiled first.
 */
`default_nettype none
module tb_gsp_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, rst_pin_n, cs_n, sclk, din, dout, oe, stb, alarm, busy, wr_stb, rx_tgl;
    logic [13:0] raw, bias, offs;
    logic [11:0] sup, aux, tmp;
    logic [7:0] wdat;
    logic [5:0] wadr;
    logic [15:0] rx_word;
    logic [31:0] seed = 32'h6b6c_336e;
    logic [15:0] exp_wr[$];
    logic [31:0] exp_rd[$];
    int mismatches = 0;
    int n_tests = 0;
    int cnt;
    logic [5:0] wadr_list[4] = '{6'h00, 6'h15, 6'h2a, 6'h3f};
    gsp_port i_dut (.clk(clk), .rst(rst), .rst_pin_n(rst_pin_n), .spi_cs_n(cs_n),
        .spi_sclk(sclk), .spi_din(din), .spi_dout(dout), .spi_dout_oe(oe),
        .sample_stb(stb), .raw_rate(raw), .rate_bias(bias), .user_offset(offs),
        .supply_raw(sup), .aux_raw(aux), .temp_raw(tmp), .alarm(alarm),
        .startup_busy(busy), .wr_addr_data(wdat), .wr_addr(wadr), .wr_stb(wr_stb));
    gsp_master i_mst (.spi_cs_n(cs_n), .spi_sclk(sclk), .spi_din(din), .spi_dout(dout),
        .spi_dout_oe(oe), .rx_word(rx_word), .rx_tgl(rx_tgl));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic results();
        $display("Tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // Note what the frame should yield, then run it; mask 0 means unchecked
    task automatic frame(input logic [15:0] w, input logic [15:0] exp, input logic [15:0] msk);
        exp_rd.push_back({exp, msk});
        if (w[15:14] == 2'b10) begin
            exp_wr.push_back({2'b00, w[13:0]});
        end
        i_mst.xfer(w);
    endtask : frame
    // New random samples, all taken on one strobe
    task automatic sample();
        @(posedge clk);
        stb <= 1'b1;
        {raw, bias, offs} <= 42'({rnd(), rnd()});
        {sup, aux, tmp} <= 36'({rnd(), rnd()});
        @(posedge clk);
        stb <= 1'b0;
    endtask : sample
    task automatic wait_ready();
        cnt = 0;
        while (busy !== 1'b0 && cnt < 1000) begin
            @(posedge clk);
            cnt++;
        end
    endtask : wait_ready
    // ****************************************
    // Clock, watchdog, monitors
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #300us;
        mismatches++;
        results();
    end
    // Every write strobe must match the oldest noted write
    always @(posedge clk) begin
        if (wr_stb === 1'b1) begin
            check({2'b00, wadr, wdat}, exp_wr.size() ? exp_wr.pop_front() : 16'hffff);
        end
    end
    always @(rx_tgl) begin
        if (exp_rd.size()) begin
            logic [31:0] e;
            e = exp_rd.pop_front();
            check(rx_word & e[15:0], e[31:16]);
        end
    end
    // Outside frames the output must be released
    always @(posedge clk) begin
        // Enable lags select by a synchroniser and a register, so look one stage late
        if (i_dut.cs_s_q[2] === 1'b1 && $time > 100ns && !busy) begin
            if (oe !== 1'b0) check({15'h0000, oe}, 16'h0000);
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        rst_pin_n = 1'b1;
        stb = 1'b0;
        {raw, bias, offs, sup, aux, tmp} = '0;
        alarm = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wait_ready();
        check({15'h0000, busy}, 16'h0000);
        // Writes to several byte addresses, random data
        foreach (wadr_list[i]) frame({2'b10, wadr_list[i], 8'(rnd())}, 16'h0, 16'h0);
        // Refused: pattern 11 and clocks with select high
        frame(16'hc0ab, 16'h0, 16'h0);
        i_mst.stray(16'(rnd()));
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) alarm <= k[0];
            sample();
            frame({2'b00, gsp_pkg::A_SUPPLY | 6'h01, 8'(rnd())}, 16'h0, 16'h0);
            frame({2'b00, gsp_pkg::A_AUX, 8'h00}, {1'b1, k[0], 2'b00, sup}, 16'hcfff);
            // One shared flag: the first read-back after a sample clears it
            frame({2'b00, gsp_pkg::A_TEMP, 8'h00}, {1'b0, k[0], 2'b00, aux}, 16'hcfff);
            frame({2'b00, gsp_pkg::A_SUPPLY, 8'h00}, {1'b0, k[0], 2'b00, tmp}, 16'hcfff);
            frame({2'b00, 6'h20, 8'h00}, {1'b0, k[0], 2'b00, sup}, 16'hcfff);
            frame({2'b00, gsp_pkg::A_ANGLE, 8'h00}, 16'h0000, 16'h3fff);
            // Null then soft reset must both zero the angle
            frame({2'b10, gsp_pkg::A_CMD, k ? 8'h80 : 8'h01}, 16'h0, 16'h0);
            frame({2'b00, gsp_pkg::A_ANGLE | 6'h01, 8'h00}, 16'h0, 16'h0);
            frame(16'h0000, 16'h0000, 16'h3fff);
        end
        // Reset pin restarts the start-up hold for its full length
        sample();
        @(posedge clk);
        rst_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        check({15'h0000, busy}, 16'h0001);
        rst_pin_n <= 1'b1;
        wait_ready();
        check(16'(cnt >= int'(gsp_pkg::START_CYC) && cnt < int'(gsp_pkg::START_CYC) + 12), 16'h1);
        frame({2'b00, gsp_pkg::A_ANGLE, 8'h00}, 16'h0, 16'h0);
        frame(16'h0000, 16'h0000, 16'h3fff);
        repeat (20) @(posedge clk);
        check(16'(exp_wr.size() + exp_rd.size()), 16'h0000);
        results();
    end
endmodule : tb_gsp_port
`default_nettype wire
